// >>> inc/scor_pkg.sv
// Behaviour
// - 0x06 release, 0x0F hold, 0x0B quick stop
// - 0x103F retargets on every target change
// - 0F to 1F homes; 0x86 resets errors
// - status bits 0-6 report drive state flags
// - status bits 7 and 9-15 report motion flags
// - signed mode byte selects seven modes
// - mode 1 positioning; 3 and -3 velocity
// - enable input loads command from preset
// - index, subindex and length code address objects
// - four-digit serial addresses with access properties
// - input port bits: limits, home, interlock
// - alarms 000.1-000.8 with their codes
// - motor configuration alarm 001.0, 0x6320
// - pre-enable alarm 010.0, 0x5443
// - position limit alarms only when setting zero
// - serial fault 080.0, direction 200.0 alarms
package scor_pkg;
  localparam logic [15:0] ADDR_POS_PRESET = 16'h0CF0;
  localparam logic [15:0] ADDR_CMD = 16'h3100;
  localparam logic [15:0] ADDR_STATUS = 16'h3200;
  localparam logic [15:0] ADDR_MODE = 16'h3500;
  localparam logic [15:0] ADDR_POS = 16'h3700;
  localparam logic [15:0] ADDR_SPEED = 16'h3B00;
  localparam logic [15:0] ADDR_CURR = 16'h3E00;
  localparam logic [15:0] ADDR_INPORT = 16'h6D00;
  localparam logic [15:0] ADDR_ALARM = 16'h2601;
  localparam logic [15:0] ADDR_ERRCODE = 16'h2602;
  localparam logic [15:0] ADDR_TARGET = 16'h4000;
  localparam logic [15:0] ADDR_LIMFN = 16'h0A13;

  localparam logic [15:0] CMD_RELEASE = 16'h0006;
  localparam logic [15:0] CMD_HOLD = 16'h000F;
  localparam logic [15:0] CMD_QSTOP = 16'h000B;
  localparam logic [15:0] CMD_ABS_ARM = 16'h002F;
  localparam logic [15:0] CMD_ABS_GO = 16'h003F;
  localparam logic [15:0] CMD_REL_ARM = 16'h004F;
  localparam logic [15:0] CMD_REL_GO = 16'h005F;
  localparam logic [15:0] CMD_IMM_ABS = 16'h103F;
  localparam logic [15:0] CMD_HOME_GO = 16'h001F;
  localparam logic [15:0] CMD_ERR_RST = 16'h0086;

  localparam logic [15:0] CMD_RESET_VAL = 16'h0006;
  localparam logic [15:0] PRESET_RESET_VAL = 16'h002F;
  localparam logic [7:0] MODE_RESET_VAL = 8'h01;
  localparam logic [7:0] LIMFN_RESET_VAL = 8'h00;

  localparam logic [7:0] MODE_POS = 8'h01;
  localparam logic [7:0] MODE_VEL = 8'h03;
  localparam logic [7:0] MODE_VEL_IMM = 8'hFD;
  localparam logic [7:0] MODE_TORQUE = 8'h04;
  localparam logic [7:0] MODE_PULSE = 8'h07;
  localparam logic [7:0] MODE_HOMING = 8'h06;
  localparam logic [7:0] MODE_INTERP = 8'h08;

  localparam logic [7:0] LEN_1B = 8'h08;
  localparam logic [7:0] LEN_2B = 8'h10;
  localparam logic [7:0] LEN_4B = 8'h20;

  localparam int ST_READY = 0;
  localparam int ST_SWON = 1;
  localparam int ST_OPEN = 2;
  localparam int ST_FAULT = 3;
  localparam int ST_VOLT = 4;
  localparam int ST_QSTOP = 5;
  localparam int ST_SWDIS = 6;
  localparam int ST_WARN = 7;
  localparam int ST_REMOTE = 9;
  localparam int ST_TREACH = 10;
  localparam int ST_ILIM = 11;
  localparam int ST_PULSE = 12;
  localparam int ST_FOLLOW = 13;
  localparam int ST_COMM = 14;
  localparam int ST_REF = 15;

  localparam int ALARM_BITS = 10;
  localparam int AL_CURR = 0;
  localparam int AL_WDOG = 1;
  localparam int AL_IRQ = 2;
  localparam int AL_CTRL = 3;
  localparam int AL_MOTOR = 4;
  localparam int AL_PREEN = 5;
  localparam int AL_PLIM = 6;
  localparam int AL_NLIM = 7;
  localparam int AL_SPI = 8;
  localparam int AL_DIR = 9;
  localparam logic [15:0] ALARM_WORD_POS [ALARM_BITS] = '{16'h0001,
    16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0100, 16'h0200,
    16'h0400, 16'h0800, 16'h2000};
  localparam logic [15:0] ALARM_CODE [ALARM_BITS] = '{16'h5210, 16'h6010,
    16'h6011, 16'h7400, 16'h6320, 16'h5443, 16'h5442, 16'h5441, 16'h6012,
    16'h8A81};

  typedef struct packed {
    logic [ALARM_BITS-1:0] cond;
  } scor_faults_t;

  typedef struct packed {
    logic pos_lim_reached;
    logic neg_lim_reached;
    logic homed;
    logic target_reached;
    logic following_err;
    logic int_limit;
    logic pulse_resp;
    logic commutation;
    logic remote;
    logic warning;
  } scor_motion_t;

  typedef struct packed {
    logic [31:0] position;
    logic [31:0] speed;
    logic [15:0] current;
  } scor_meas_t;

  typedef struct packed {
    logic release_shaft;
    logic hold_shaft;
    logic quick_stop;
    logic start_abs;
    logic start_rel;
    logic retarget;
    logic start_home;
  } scor_cmd_t;

  typedef enum logic [1:0] {
    SCOR_SW_DISABLED,
    SCOR_SW_ON,
    SCOR_OP_ENABLED,
    SCOR_FAULTED
  } scor_state_t;
endpackage

// >>> design/scor_sync.sv
`timescale 1ns/1ns
`default_nettype none
module scor_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_out;

  // a bit only changes once the second and third stages agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_out[i] = (s2[i] == s3[i]) ? s3[i] : sync_out[i];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      sync_out <= '0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      sync_out <= next_out;
    end
  end
endmodule
`default_nettype wire

// >>> design/scor_regs.sv
`timescale 1ns/1ns
`default_nettype none
module scor_regs (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic obj_wr,
  input wire logic obj_rd,
  input wire logic [15:0] obj_addr,
  input wire logic [31:0] obj_wdata,
  output logic [31:0] obj_rdata,
  output logic obj_ack,
  output logic obj_err,
  input wire logic [3:0] port_pins,
  input wire logic enable_pin,
  input wire logic pre_enable_pin,
  input wire logic enable_in_assigned,
  input wire logic pre_enable_assigned,
  input wire scor_pkg::scor_faults_t faults,
  input wire scor_pkg::scor_motion_t motion,
  input wire scor_pkg::scor_meas_t meas,
  output scor_pkg::scor_cmd_t cmd,
  output logic [7:0] op_mode,
  output logic [31:0] target_pos,
  output logic [15:0] status_word
);
  logic [15:0] command;
  logic [15:0] prev_cmd;
  logic [15:0] preset;
  logic [7:0] limfn;
  logic [scor_pkg::ALARM_BITS-1:0] alarms;
  logic [15:0] err_code;
  scor_pkg::scor_state_t state;
  scor_pkg::scor_meas_t meas_q;
  logic [3:0] port_q;
  logic [3:0] port_s;
  logic [1:0] en_s;
  logic en_prev;

  logic [15:0] next_command;
  logic [15:0] next_preset;
  logic [7:0] next_limfn;
  logic [7:0] next_op_mode;
  logic [31:0] next_target;
  logic [scor_pkg::ALARM_BITS-1:0] next_alarms;
  logic [scor_pkg::ALARM_BITS-1:0] cond;
  logic [15:0] next_err_code;
  scor_pkg::scor_state_t next_state;
  scor_pkg::scor_cmd_t next_cmd;
  logic [31:0] next_rdata;
  logic next_ack;
  logic next_err;
  logic [15:0] next_status;
  logic err_reset;
  logic mapped;
  logic [15:0] alarm_word;

  scor_sync #(.WIDTH(6)) u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in({enable_pin, pre_enable_pin, port_pins}),
    .sync_out({en_s, port_s})
  );

  always_comb begin
    cond = faults.cond;
    // inactive pre-enable input while enabled or enabling
    cond[scor_pkg::AL_PREEN] = pre_enable_assigned && !en_s[0] &&
      (state == scor_pkg::SCOR_OP_ENABLED || command == scor_pkg::CMD_HOLD
      || en_s[1]);
    cond[scor_pkg::AL_PLIM] = faults.cond[scor_pkg::AL_PLIM] &&
      motion.homed && motion.pos_lim_reached &&
      limfn == scor_pkg::LIMFN_RESET_VAL;
    cond[scor_pkg::AL_NLIM] = faults.cond[scor_pkg::AL_NLIM] &&
      motion.homed && motion.neg_lim_reached &&
      limfn == scor_pkg::LIMFN_RESET_VAL;
    // host sees the alarm word layout, not the internal bit order
    alarm_word = 16'h0000;
    for (int i = 0; i < scor_pkg::ALARM_BITS; i++) begin
      if (alarms[i]) begin
        alarm_word = alarm_word | scor_pkg::ALARM_WORD_POS[i];
      end
    end
  end

  always_comb begin
    mapped = 1'b1;
    next_rdata = obj_rdata;
    next_command = command;
    next_preset = preset;
    next_limfn = limfn;
    next_op_mode = op_mode;
    next_target = target_pos;
    unique case (obj_addr)
      scor_pkg::ADDR_POS_PRESET: next_rdata = {16'h0000, preset};
      scor_pkg::ADDR_CMD: next_rdata = {16'h0000, command};
      scor_pkg::ADDR_STATUS: next_rdata = {16'h0000, status_word};
      scor_pkg::ADDR_MODE: next_rdata = {24'h000000, op_mode};
      scor_pkg::ADDR_POS: next_rdata = meas_q.position;
      scor_pkg::ADDR_SPEED: next_rdata = meas_q.speed;
      scor_pkg::ADDR_CURR: next_rdata = {16'h0000, meas_q.current};
      scor_pkg::ADDR_INPORT: next_rdata = {28'h0000000, port_q};
      scor_pkg::ADDR_ALARM: next_rdata = {16'h0000, alarm_word};
      scor_pkg::ADDR_ERRCODE: next_rdata = {16'h0000, err_code};
      scor_pkg::ADDR_TARGET: next_rdata = target_pos;
      scor_pkg::ADDR_LIMFN: next_rdata = {24'h000000, limfn};
      default: mapped = 1'b0;
    endcase
    if (!obj_rd) begin
      next_rdata = obj_rdata;
    end
    // any unmapped access answers zero alongside the error flag
    if ((obj_rd || obj_wr) && !mapped) begin
      next_rdata = 32'h00000000;
    end
    if (obj_wr) begin
      case (obj_addr)
        scor_pkg::ADDR_POS_PRESET: next_preset = obj_wdata[15:0];
        scor_pkg::ADDR_CMD: next_command = obj_wdata[15:0];
        scor_pkg::ADDR_MODE: next_op_mode = obj_wdata[7:0];
        scor_pkg::ADDR_TARGET: next_target = obj_wdata;
        scor_pkg::ADDR_LIMFN: next_limfn = obj_wdata[7:0];
        default: ;
      endcase
    end
    // rising drive-enable input loads the preset command
    if (enable_in_assigned && en_s[1] && !en_prev) begin
      next_command = preset;
    end
    next_ack = obj_wr || obj_rd;
    next_err = (obj_wr || obj_rd) && !mapped;
  end

  always_comb begin
    err_reset = command == scor_pkg::CMD_ERR_RST &&
      prev_cmd != scor_pkg::CMD_ERR_RST;
    // alarms latch; reset clears only bits whose cause is gone
    next_alarms = alarms | cond;
    if (err_reset) begin
      next_alarms = cond;
    end
    next_err_code = err_code;
    for (int i = scor_pkg::ALARM_BITS - 1; i >= 0; i--) begin
      if (next_alarms[i]) begin
        next_err_code = scor_pkg::ALARM_CODE[i];
      end
    end
    if (next_alarms == '0) begin
      next_err_code = 16'h0000;
    end
    next_cmd = '0;
    next_cmd.release_shaft = command == scor_pkg::CMD_RELEASE;
    next_cmd.hold_shaft = command[3:0] == 4'hF && alarms == '0;
    next_cmd.quick_stop = command == scor_pkg::CMD_QSTOP;
    next_cmd.start_abs = command == scor_pkg::CMD_ABS_GO &&
      prev_cmd == scor_pkg::CMD_ABS_ARM;
    next_cmd.start_rel = command == scor_pkg::CMD_REL_GO &&
      prev_cmd == scor_pkg::CMD_REL_ARM;
    next_cmd.retarget = command == scor_pkg::CMD_IMM_ABS &&
      (prev_cmd != scor_pkg::CMD_IMM_ABS || next_target != target_pos);
    next_cmd.start_home = command == scor_pkg::CMD_HOME_GO &&
      prev_cmd == scor_pkg::CMD_HOLD;
    if (alarms != '0) begin
      next_cmd.start_abs = 1'b0;
      next_cmd.start_rel = 1'b0;
      next_cmd.retarget = 1'b0;
      next_cmd.start_home = 1'b0;
    end
    case (state)
      scor_pkg::SCOR_SW_DISABLED: next_state = command[3:0] == 4'hF ?
        scor_pkg::SCOR_OP_ENABLED : (command == scor_pkg::CMD_RELEASE ?
        scor_pkg::SCOR_SW_ON : scor_pkg::SCOR_SW_DISABLED);
      scor_pkg::SCOR_SW_ON: next_state = command[3:0] == 4'hF ?
        scor_pkg::SCOR_OP_ENABLED : scor_pkg::SCOR_SW_ON;
      scor_pkg::SCOR_OP_ENABLED: next_state =
        command == scor_pkg::CMD_RELEASE ? scor_pkg::SCOR_SW_ON :
        (command == scor_pkg::CMD_QSTOP ? scor_pkg::SCOR_SW_DISABLED :
        scor_pkg::SCOR_OP_ENABLED);
      scor_pkg::SCOR_FAULTED: next_state = next_alarms == '0 ?
        scor_pkg::SCOR_SW_DISABLED : scor_pkg::SCOR_FAULTED;
      default: next_state = scor_pkg::SCOR_SW_DISABLED;
    endcase
    if (next_alarms != '0) begin
      next_state = scor_pkg::SCOR_FAULTED;
    end
    next_status = 16'h0000;
    next_status[scor_pkg::ST_READY] = state != scor_pkg::SCOR_SW_DISABLED &&
      state != scor_pkg::SCOR_FAULTED;
    next_status[scor_pkg::ST_SWON] = state == scor_pkg::SCOR_SW_ON ||
      state == scor_pkg::SCOR_OP_ENABLED;
    next_status[scor_pkg::ST_OPEN] = state == scor_pkg::SCOR_OP_ENABLED;
    next_status[scor_pkg::ST_FAULT] = alarms != '0;
    next_status[scor_pkg::ST_VOLT] = state == scor_pkg::SCOR_OP_ENABLED;
    next_status[scor_pkg::ST_QSTOP] = command != scor_pkg::CMD_QSTOP;
    next_status[scor_pkg::ST_SWDIS] = state == scor_pkg::SCOR_SW_DISABLED;
    next_status[scor_pkg::ST_WARN] = motion.warning;
    next_status[scor_pkg::ST_REMOTE] = motion.remote;
    next_status[scor_pkg::ST_TREACH] = motion.target_reached;
    next_status[scor_pkg::ST_ILIM] = motion.int_limit;
    next_status[scor_pkg::ST_PULSE] = motion.pulse_resp;
    next_status[scor_pkg::ST_FOLLOW] = motion.following_err;
    next_status[scor_pkg::ST_COMM] = motion.commutation;
    next_status[scor_pkg::ST_REF] = motion.homed;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      command <= scor_pkg::CMD_RESET_VAL;
      prev_cmd <= scor_pkg::CMD_RESET_VAL;
      preset <= scor_pkg::PRESET_RESET_VAL;
      limfn <= scor_pkg::LIMFN_RESET_VAL;
      op_mode <= scor_pkg::MODE_RESET_VAL;
      target_pos <= 32'h00000000;
      alarms <= '0;
      err_code <= 16'h0000;
      state <= scor_pkg::SCOR_SW_DISABLED;
      cmd <= '0;
      status_word <= 16'h0000;
      obj_rdata <= 32'h00000000;
      obj_ack <= 1'b0;
      obj_err <= 1'b0;
      meas_q <= '0;
      port_q <= 4'h0;
      en_prev <= 1'b0;
    end else begin
      command <= next_command;
      prev_cmd <= command;
      preset <= next_preset;
      limfn <= next_limfn;
      op_mode <= next_op_mode;
      target_pos <= next_target;
      alarms <= next_alarms;
      err_code <= next_err_code;
      state <= next_state;
      cmd <= next_cmd;
      status_word <= next_status;
      obj_rdata <= next_rdata;
      obj_ack <= next_ack;
      obj_err <= next_err;
      meas_q <= meas;
      port_q <= port_s;
      en_prev <= en_s[1];
    end
  end
endmodule
`default_nettype wire

// >>> bench/scor_regs_properties.sv
`timescale 1ns/1ns
`default_nettype none
module scor_regs_checker (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic obj_wr,
  input wire logic obj_rd,
  input wire logic [15:0] obj_addr,
  input wire logic [31:0] obj_wdata,
  input wire logic [31:0] obj_rdata,
  input wire logic obj_ack,
  input wire logic obj_err,
  input wire scor_pkg::scor_faults_t faults,
  input wire scor_pkg::scor_motion_t motion,
  input wire scor_pkg::scor_cmd_t cmd,
  input wire logic [15:0] status_word
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  property p_ack_follows;
    (obj_wr || obj_rd) |=> obj_ack;
  endproperty
  a_ack_follows:
    assert property (p_ack_follows) else $error("no ack after request");

  property p_no_stray_ack;
    !(obj_wr || obj_rd) |=> !obj_ack && !obj_err;
  endproperty
  a_no_stray_ack:
    assert property (p_no_stray_ack) else $error("ack without request");

  property p_err_unmapped;
    obj_err |-> obj_ack && obj_rdata == 32'h0;
  endproperty
  a_err_unmapped:
    assert property (p_err_unmapped) else $error("bad error answer");

  property p_status_read;
    obj_rd && !obj_wr && obj_addr == scor_pkg::ADDR_STATUS
      |=> obj_rdata == {16'h0, $past(status_word)};
  endproperty
  a_status_read:
    assert property (p_status_read) else $error("status read wrong");

  property p_hold;
    obj_wr && obj_addr == scor_pkg::ADDR_CMD
      && obj_wdata[15:0] == scor_pkg::CMD_HOLD
      |-> ##[1:3] cmd.hold_shaft && !cmd.release_shaft;
  endproperty
  a_hold:
    assert property (p_hold) else $error("hold not decoded");

  property p_qstop;
    obj_wr && obj_addr == scor_pkg::ADDR_CMD
      && obj_wdata[15:0] == scor_pkg::CMD_QSTOP
      |-> ##[1:3] cmd.quick_stop && !cmd.hold_shaft;
  endproperty
  a_qstop:
    assert property (p_qstop) else $error("quick stop not decoded");

  property p_start_pulse;
    (cmd.start_abs || cmd.start_rel) |=> !cmd.start_abs && !cmd.start_rel;
  endproperty
  a_start_pulse:
    assert property (p_start_pulse) else $error("start longer than one");

  property p_fault_bit;
    ({faults.cond[9:8], faults.cond[4:0]} != 7'h0)
      |-> ##[1:4] status_word[scor_pkg::ST_FAULT];
  endproperty
  a_fault_bit:
    assert property (p_fault_bit) else $error("fault bit not set");

  property p_target_flag;
    motion.target_reached [*4] |-> status_word[scor_pkg::ST_TREACH];
  endproperty
  a_target_flag:
    assert property (p_target_flag) else $error("target flag missing");

  property p_release;
    obj_wr && obj_addr == scor_pkg::ADDR_CMD
      && obj_wdata[15:0] == scor_pkg::CMD_RELEASE
      |-> ##[1:3] cmd.release_shaft && !cmd.hold_shaft;
  endproperty
  a_release:
    assert property (p_release) else $error("release not decoded");
endmodule

bind scor_regs scor_regs_checker scor_regs_checker_inst (
  .core_clk(core_clk), .rst_b(rst_b), .obj_wr(obj_wr), .obj_rd(obj_rd),
  .obj_addr(obj_addr), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata),
  .obj_ack(obj_ack), .obj_err(obj_err), .faults(faults),
  .motion(motion), .cmd(cmd), .status_word(status_word)
);
`default_nettype wire

// >>> bench/scor_host.sv
`timescale 1ns/1ns
`default_nettype none
module scor_host (
  input wire logic core_clk,
  input wire logic obj_ack,
  input wire logic obj_err,
  input wire logic [31:0] obj_rdata,
  output logic obj_wr,
  output logic obj_rd,
  output logic [15:0] obj_addr,
  output logic [31:0] obj_wdata
);
  initial begin
    obj_wr = 1'b0;
    obj_rd = 1'b0;
    obj_addr = 16'h0000;
    obj_wdata = 32'h0;
  end
  // one object access by its four-digit address
  task automatic xfer(input logic w, input logic [15:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e,
      output logic k);
    @(negedge core_clk);
    obj_wr = w;
    obj_rd = !w;
    obj_addr = a;
    obj_wdata = d;
    @(negedge core_clk);
    k = obj_ack;
    e = obj_err;
    q = obj_rdata;
    obj_wr = 1'b0;
    obj_rd = 1'b0;
    // a released bus never keeps its last value
    obj_addr = ~a;
    obj_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic core_clk, rst_b, obj_wr, obj_rd, obj_ack, obj_err, e, k;
  logic [15:0] obj_addr, status_word;
  logic [31:0] obj_wdata, obj_rdata, target_pos, q;
  logic [3:0] port_pins;
  logic enable_pin, pre_enable_pin, enable_in_assigned, pre_enable_assigned;
  logic [7:0] op_mode;
  scor_pkg::scor_faults_t faults;
  scor_pkg::scor_motion_t motion;
  scor_pkg::scor_meas_t meas;
  scor_pkg::scor_cmd_t cmd;
  int errors = 0, check_count = 0, cycles = 0;
  int n_abs = 0, n_rel = 0, n_home = 0, n_ret = 0;

  scor_regs scor_regs_inst (.core_clk(core_clk), .rst_b(rst_b),
    .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_addr(obj_addr),
    .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_ack(obj_ack),
    .obj_err(obj_err), .port_pins(port_pins), .enable_pin(enable_pin),
    .pre_enable_pin(pre_enable_pin), .enable_in_assigned(enable_in_assigned),
    .pre_enable_assigned(pre_enable_assigned), .faults(faults),
    .motion(motion), .meas(meas), .cmd(cmd), .op_mode(op_mode),
    .target_pos(target_pos), .status_word(status_word));
  scor_host scor_host_inst (.core_clk(core_clk), .obj_ack(obj_ack),
    .obj_err(obj_err), .obj_rdata(obj_rdata), .obj_wr(obj_wr),
    .obj_rd(obj_rd), .obj_addr(obj_addr), .obj_wdata(obj_wdata));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    n_abs <= n_abs + int'(cmd.start_abs);
    n_rel <= n_rel + int'(cmd.start_rel);
    n_home <= n_home + int'(cmd.start_home);
    n_ret <= n_ret + int'(cmd.retarget);
    if (cycles == 5000) begin
      errors = errors + 1;
      final_report();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    scor_host_inst.xfer(1'b1, a, d, q, e, k);
    chk("write ack", 32'h1, {31'h0, k});
  endtask
  task automatic rdc(input string n, input logic [15:0] a, logic [31:0] x);
    scor_host_inst.xfer(1'b0, a, 32'h0, q, e, k);
    chk(n, x, q);
  endtask

  task automatic t_reset();
    rdc("command", scor_pkg::ADDR_CMD, 32'h6);
    rdc("preset", scor_pkg::ADDR_POS_PRESET, 32'h2F);
    chk("mode", 32'h1, {24'h0, op_mode});
    // released shaft: ready and switched on, quick stop bit inactive-high
    rdc("status", scor_pkg::ADDR_STATUS, 32'h23);
  endtask
  task automatic t_commands();
    logic [15:0] c [3] = '{16'h000F, 16'h000B, 16'h0006};
    logic [2:0] x [3] = '{3'b010, 3'b001, 3'b100};
    for (int i = 0; i < 3; i++) begin
      wr(scor_pkg::ADDR_CMD, {16'h0, c[i]});
      repeat (2) @(negedge core_clk);
      chk("shaft", {29'h0, x[i]}, {29'h0, cmd[6:4]});
    end
  endtask
  task automatic t_moves();
    // 3F after 5F is no arming transition and must not start
    logic [15:0] s [8] = '{16'h0F, 16'h2F, 16'h3F, 16'h4F, 16'h5F, 16'h3F,
      16'h0F, 16'h1F};
    for (int i = 0; i < 8; i++) begin
      wr(scor_pkg::ADDR_CMD, {16'h0, s[i]});
    end
    repeat (3) @(negedge core_clk);
    chk("abs starts", 32'd1, n_abs);
    chk("rel starts", 32'd1, n_rel);
    chk("home starts", 32'd1, n_home);
    wr(scor_pkg::ADDR_CMD, {16'h0, scor_pkg::CMD_IMM_ABS});
    wr(scor_pkg::ADDR_TARGET, 32'h12345678);
    wr(scor_pkg::ADDR_TARGET, 32'h00000100);
    repeat (3) @(negedge core_clk);
    // entering the immediate mode moves once, then once per change
    chk("retargets", 32'd3, n_ret);
    chk("target", 32'h100, target_pos);
  endtask
  task automatic t_readonly();
    meas = {32'h00AB_CDEF, 32'h0000_1234, 16'h0123};
    port_pins = 4'hA;
    wr(scor_pkg::ADDR_POS, 32'h5555_5555);
    repeat (6) @(negedge core_clk);
    rdc("position", scor_pkg::ADDR_POS, 32'h00AB_CDEF);
    rdc("speed", scor_pkg::ADDR_SPEED, 32'h1234);
    rdc("current", scor_pkg::ADDR_CURR, 32'h0123);
    rdc("inputs", scor_pkg::ADDR_INPORT, 32'hA);
    rdc("unmapped", 16'h1234, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
  endtask
  task automatic t_modes_status();
    logic [7:0] m [7] = '{8'h01, 8'h03, 8'hFD, 8'h04, 8'h07, 8'h06, 8'h08};
    for (int i = 0; i < 7; i++) begin
      wr(scor_pkg::ADDR_MODE, {24'h0, m[i]});
      chk("mode", {24'h0, m[i]}, {24'h0, op_mode});
    end
    motion = '1;
    repeat (6) @(negedge core_clk);
    chk("upper status", 32'h1FD, {23'h0, status_word[15:7]});
    motion = '0;
  endtask
  task automatic t_enable();
    wr(scor_pkg::ADDR_POS_PRESET, 32'h4F);
    enable_in_assigned = 1'b1;
    enable_pin = 1'b1;
    pre_enable_assigned = 1'b1;
    repeat (8) @(negedge core_clk);
    rdc("loaded command", scor_pkg::ADDR_CMD, 32'h4F);
    rdc("pre-enable", scor_pkg::ADDR_ALARM, 32'h100);
    enable_pin = 1'b0;
    pre_enable_pin = 1'b1;
    wr(scor_pkg::ADDR_CMD, 32'h6);
    wr(scor_pkg::ADDR_CMD, {16'h0, scor_pkg::CMD_ERR_RST});
    rdc("alarm cleared", scor_pkg::ADDR_ALARM, 32'h0);
  endtask
  task automatic t_alarms();
    motion.homed = 1'b1;
    motion.pos_lim_reached = 1'b1;
    motion.neg_lim_reached = 1'b1;
    for (int i = 0; i < scor_pkg::ALARM_BITS; i++) begin
      if (i != scor_pkg::AL_PREEN) begin
        faults.cond = 10'(1 << i);
        wr(scor_pkg::ADDR_CMD, 32'h6);
        wr(scor_pkg::ADDR_CMD, {16'h0, scor_pkg::CMD_ERR_RST});
        chk("fault bit", 32'h1, {31'h0, status_word[3]});
        rdc("alarm", scor_pkg::ADDR_ALARM, {16'h0,
          scor_pkg::ALARM_WORD_POS[i]});
        rdc("code", scor_pkg::ADDR_ERRCODE, {16'h0,
          scor_pkg::ALARM_CODE[i]});
        faults.cond = '0;
        wr(scor_pkg::ADDR_CMD, 32'h6);
        wr(scor_pkg::ADDR_CMD, {16'h0, scor_pkg::CMD_ERR_RST});
        rdc("alarm gone", scor_pkg::ADDR_ALARM, 32'h0);
      end
    end
    wr(scor_pkg::ADDR_LIMFN, 32'h1);
    faults.cond = 10'(1 << scor_pkg::AL_PLIM);
    repeat (4) @(negedge core_clk);
    rdc("limit off", scor_pkg::ADDR_ALARM, 32'h0);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    port_pins = 4'h0;
    enable_pin = 1'b0;
    pre_enable_pin = 1'b0;
    enable_in_assigned = 1'b0;
    pre_enable_assigned = 1'b0;
    faults = '0;
    motion = '0;
    meas = '0;
    repeat (5) @(negedge core_clk);
    rst_b = 1'b1;
    t_reset();
    $display("reset values done");
    t_commands();
    $display("shaft commands done");
    t_moves();
    $display("move starts done");
    t_readonly();
    $display("read-only objects done");
    t_modes_status();
    $display("modes and status done");
    t_enable();
    $display("enable input done");
    t_alarms();
    $display("alarms done");
    final_report();
  end
endmodule
`default_nettype wire
